/* File: verilog/xoc_ctrl.sv */
// crystal oscillator control: registers, run logic, start-up and interrupts
//
// Contract
// - agc bit adjusts main gain while running
// - gain codes 0-4 valid, 5-7 reserved
// - main on-demand: run only when requested
// - main not on-demand: run whenever enabled
// - standby stops main unless keep bit set
// - main crystal select picks crystal or clock
// - main enable bit turns oscillator on
// - freeze bit blocks writes to slow control
// - slow start-up counted on low-power clock
// - start-up codes pick 1 to 131072 cycles
// - three slow crystal cycles before ready
// - slow on-demand: run only when requested
// - slow not on-demand: run whenever enabled
// - standby stops slow unless keep bit set
// - slow amplitude control bit enables control
// - slow output-enable bit gates clock output
// - slow crystal select picks crystal or clock
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "xoc_defs.svh"

module xoc_ctrl import xoc_pkg::*; (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // system state and clock requests
   input wire logic STANDBY,
   input wire logic REQ_MAIN,
   input wire logic REQ_SLOW,
   // oscillator clocks seen from the pads and the low-power source
   input wire logic MAIN_OSC_CLK,
   input wire logic SLOW_OSC_CLK,
   input wire logic ULP_OSC_CLK,
   // main crystal oscillator controls
   output logic MAIN_OSC_EN,
   output logic MAIN_AGC_EN,
   output logic [2:0] MAIN_GAIN,
   output logic MAIN_CRYSTAL_SEL,
   output logic MAIN_READY,
   // slow crystal oscillator controls
   output logic SLOW_OSC_EN,
   output logic SLOW_AMP_EN,
   output logic SLOW_CLK_OUT_EN,
   output logic SLOW_CRYSTAL_SEL,
   output logic SLOW_READY,
   // interrupt
   output logic IRQ
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [15:0] main_crystal_control;
   logic [15:0] crystal32k_control;
   logic [`XOC_NUM_EVT-1:0] int_flag;
   logic [`XOC_NUM_EVT-1:0] int_mask;
   logic [`XOC_NUM_EVT-1:0] read_snap;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic hit_flag;
   logic hit_mask;
   logic hit_status;
   logic hit_main;
   logic hit_slow;
   logic hit_any;
   logic wr_access;
   logic rd_access;
   logic rd_setup;

   always_comb begin
      hit_flag = 1'b0;
      hit_mask = 1'b0;
      hit_status = 1'b0;
      hit_main = 1'b0;
      hit_slow = 1'b0;
      if (PADDR == `XOC_ADDR_FLAG) begin
         hit_flag = 1'b1;
      end else if (PADDR == `XOC_ADDR_MASK) begin
         hit_mask = 1'b1;
      end else if (PADDR == `XOC_ADDR_STATUS) begin
         hit_status = 1'b1;
      end else if (PADDR == `XOC_ADDR_MAIN) begin
         hit_main = 1'b1;
      end else if (PADDR == `XOC_ADDR_SLOW) begin
         hit_slow = 1'b1;
      end
   end

   assign hit_any = hit_flag | hit_mask | hit_status | hit_main | hit_slow;
   assign wr_access = PSEL & PENABLE & PWRITE & hit_any;
   assign rd_access = PSEL & PENABLE & ~PWRITE & hit_any;
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

   // zero wait states; a miss is flagged but harms nothing
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~hit_any;

   // ---------------------------------------------------------------
   // pin synchronisers and edge detect
   // ---------------------------------------------------------------
   logic [`XOC_NUM_PIN-1:0] pin_raw;
   logic [`XOC_NUM_PIN-1:0] pin_tick;

   assign pin_raw = {ULP_OSC_CLK, SLOW_OSC_CLK, MAIN_OSC_CLK};

   // the system clock must run well above a sampled pin clock,
   // so a fast main crystal only ever shows as a slower alias
   genvar gp;
   generate
      for (gp = 0; gp < `XOC_NUM_PIN; gp = gp + 1) begin : g_pin
         logic meta;
         logic sync;
         logic last;
         always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
               meta <= 1'b0;
               sync <= 1'b0;
               last <= 1'b0;
            end else begin
               meta <= pin_raw[gp];
               sync <= meta;
               last <= sync;
            end
         end
         assign pin_tick[gp] = sync & ~last;
      end
   endgenerate

   // ---------------------------------------------------------------
   // run decisions
   // ---------------------------------------------------------------
   logic run_main;
   logic run_slow;
   logic gain_bad;
   logic slow_locked;

   // enable gates all; on-demand needs a request; standby needs keep
   assign run_main = main_crystal_control[`XOC_B_EN]
      & (~main_crystal_control[`XOC_B_RUN_ON_REQUEST] | REQ_MAIN)
      & (~STANDBY | main_crystal_control[`XOC_B_STANDBY]);
   assign run_slow = crystal32k_control[`XOC_B_EN]
      & (~crystal32k_control[`XOC_B_RUN_ON_REQUEST] | REQ_SLOW)
      & (~STANDBY | crystal32k_control[`XOC_B_STANDBY]);

   assign gain_bad = PWDATA[`XOC_F_GAIN] > `XOC_GAIN_MAX;
   assign slow_locked = crystal32k_control[`XOC_B_FREEZE];

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         main_crystal_control <= `XOC_MAIN_RESET;
      end else if (wr_access && hit_main) begin
         main_crystal_control <= PWDATA[15:0] & `XOC_MAIN_WMASK;
         // a reserved gain code leaves the old gain in place
         if (gain_bad) begin
            main_crystal_control[`XOC_F_GAIN] <= main_crystal_control[`XOC_F_GAIN];
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         crystal32k_control <= `XOC_SLOW_RESET;
      end else if (wr_access && hit_slow && !slow_locked) begin
         crystal32k_control <= PWDATA[15:0] & `XOC_SLOW_WMASK;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         int_mask <= '0;
      end else if (wr_access && hit_mask) begin
         int_mask <= PWDATA[`XOC_NUM_EVT-1:0];
      end
   end

   // ---------------------------------------------------------------
   // start-up length lookup
   // ---------------------------------------------------------------
   function automatic logic [`XOC_SU_W-1:0] su_len(input logic [2:0] code);
      logic [`XOC_SU_W-1:0] len;
      len = `XOC_SU_LEN0;
      case (code)
         3'h0: len = `XOC_SU_LEN0;
         3'h1: len = `XOC_SU_LEN1;
         3'h2: len = `XOC_SU_LEN2;
         3'h3: len = `XOC_SU_LEN3;
         3'h4: len = `XOC_SU_LEN4;
         3'h5: len = `XOC_SU_LEN5;
         3'h6: len = `XOC_SU_LEN6;
         3'h7: len = `XOC_SU_LEN7;
         default: len = `XOC_SU_LEN0;
      endcase
      return len;
   endfunction

   // ---------------------------------------------------------------
   // start-up sequencers, index 0 main, index 1 slow
   // ---------------------------------------------------------------
   xoc_start_req_t su_req [2];
   logic [1:0] su_ready;
   logic [1:0] run_q;

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         run_q <= 2'h0;
      end else begin
         run_q <= {run_slow, run_main};
      end
   end

   // main start-up length is not programmable here: shortest setting
   always_comb begin
      su_req[0].run = run_q[0];
      su_req[0].ulp_tick = pin_tick[2];
      su_req[0].osc_tick = pin_tick[0];
      su_req[0].length = `XOC_SU_LEN0;
      su_req[1].run = run_q[1];
      su_req[1].ulp_tick = pin_tick[2];
      su_req[1].osc_tick = pin_tick[1];
      su_req[1].length = su_len(crystal32k_control[`XOC_F_STARTUP]);
   end

   genvar gs;
   generate
      for (gs = 0; gs < 2; gs = gs + 1) begin : g_su
         xoc_startup u_startup (
            .clk(CLK_SYS),
            .rst(RST),
            .req(su_req[gs]),
            .ready(su_ready[gs]),
            .state()
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // oscillator outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         MAIN_OSC_EN <= 1'b0;
         MAIN_AGC_EN <= 1'b0;
         MAIN_GAIN <= 3'h0;
         MAIN_CRYSTAL_SEL <= 1'b0;
         SLOW_OSC_EN <= 1'b0;
         SLOW_AMP_EN <= 1'b0;
         SLOW_CLK_OUT_EN <= 1'b0;
         SLOW_CRYSTAL_SEL <= 1'b0;
      end else begin
         MAIN_OSC_EN <= run_main;
         // gain loop only acts on a running oscillator
         MAIN_AGC_EN <= run_main & main_crystal_control[`XOC_B_AGC];
         // gain always driven; the loop starts from this value
         MAIN_GAIN <= main_crystal_control[`XOC_F_GAIN];
         MAIN_CRYSTAL_SEL <= main_crystal_control[`XOC_B_XTAL];
         SLOW_OSC_EN <= run_slow;
         SLOW_AMP_EN <= run_slow & crystal32k_control[`XOC_B_AMP];
         SLOW_CLK_OUT_EN <= crystal32k_control[`XOC_B_OUT32];
         SLOW_CRYSTAL_SEL <= crystal32k_control[`XOC_B_XTAL];
      end
   end

   assign MAIN_READY = su_ready[0];
   assign SLOW_READY = su_ready[1];

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------
   logic [1:0] ready_q;
   logic [`XOC_NUM_EVT-1:0] evt;

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ready_q <= 2'h0;
      end else begin
         ready_q <= su_ready;
      end
   end

   // ready rose, ready fell, gain rejected, locked write refused
   assign evt = {wr_access & hit_slow & slow_locked,
                 wr_access & hit_main & gain_bad,
                 ready_q & ~su_ready,
                 su_ready & ~ready_q};

   // clear only what the read returned; a new event always wins
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         int_flag <= '0;
      end else if (rd_access && hit_flag) begin
         int_flag <= (int_flag & ~read_snap) | evt;
      end else begin
         int_flag <= int_flag | evt;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(int_flag & int_mask);
      end
   end

   // ---------------------------------------------------------------
   // read data, captured in the setup cycle
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
         read_snap <= '0;
      end else if (rd_setup) begin
         PRDATA <= 32'h00000000;
         read_snap <= '0;
         if (hit_flag) begin
            PRDATA[`XOC_NUM_EVT-1:0] <= int_flag;
            read_snap <= int_flag;
         end else if (hit_mask) begin
            PRDATA[`XOC_NUM_EVT-1:0] <= int_mask;
         end else if (hit_status) begin
            PRDATA[3:0] <= {run_q, su_ready};
         end else if (hit_main) begin
            PRDATA[15:0] <= main_crystal_control;
         end else if (hit_slow) begin
            PRDATA[15:0] <= crystal32k_control;
         end
      end
   end

endmodule

`default_nettype wire

/* File: verilog/xoc_defs.svh */
// constants for the crystal oscillator control block
`ifndef XOC_DEFS_SVH
`define XOC_DEFS_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define XOC_ADDR_W 12
`define XOC_ADDR_FLAG 12'h000
`define XOC_ADDR_MASK 12'h004
`define XOC_ADDR_STATUS 12'h00c
`define XOC_ADDR_MAIN 12'h010
`define XOC_ADDR_SLOW 12'h014

// ---------------------------------------------------------------
// reset values and writable bits
// ---------------------------------------------------------------
`define XOC_MAIN_RESET 16'h0080
`define XOC_SLOW_RESET 16'h0080
`define XOC_MAIN_WMASK 16'h0fc6
`define XOC_SLOW_WMASK 16'h17ee

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define XOC_B_AGC 11
`define XOC_F_GAIN 10:8
`define XOC_B_FREEZE 12
`define XOC_F_STARTUP 10:8
`define XOC_B_RUN_ON_REQUEST 7
`define XOC_B_STANDBY 6
`define XOC_B_AMP 5
`define XOC_B_OUT32 3
`define XOC_B_XTAL 2
`define XOC_B_EN 1

// ---------------------------------------------------------------
// gain codes, start-up lengths in low-power cycles, sync length
// ---------------------------------------------------------------
`define XOC_GAIN_MAX 3'h4
`define XOC_SU_W 18
`define XOC_SU_LEN0 18'h00001
`define XOC_SU_LEN1 18'h00020
`define XOC_SU_LEN2 18'h00800
`define XOC_SU_LEN3 18'h01000
`define XOC_SU_LEN4 18'h04000
`define XOC_SU_LEN5 18'h08000
`define XOC_SU_LEN6 18'h10000
`define XOC_SU_LEN7 18'h20000
`define XOC_SYNC_LAST 2'h2
`define XOC_NUM_EVT 6
`define XOC_NUM_PIN 3

`endif

/* File: verilog/xoc_pkg.sv */
// types shared by the crystal oscillator control block
package xoc_pkg;

   // start-up sequencer states, one-hot
   typedef enum logic [3:0] {
      XOC_ST_IDLE  = 4'b0001,
      XOC_ST_COUNT = 4'b0010,
      XOC_ST_SYNC  = 4'b0100,
      XOC_ST_READY = 4'b1000
   } xoc_state_t;

   // what one start-up sequencer needs each cycle
   typedef struct packed {
      logic run;
      logic ulp_tick;
      logic osc_tick;
      logic [17:0] length;
   } xoc_start_req_t;

endpackage

/* File: verilog/xoc_startup.sv */
// start-up counter and ready sequencer for one oscillator
`timescale 1ns/1ps
`default_nettype none
`include "xoc_defs.svh"

module xoc_startup import xoc_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request
   input wire xoc_start_req_t req,
   // state
   output logic ready,
   output var xoc_state_t state
);

   logic [`XOC_SU_W-1:0] cnt;
   logic [1:0] sync_cnt;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= XOC_ST_IDLE;
         cnt <= '0;
         sync_cnt <= 2'h0;
      end else if (!req.run) begin
         // stopping drops ready; the next run restarts the full count
         state <= XOC_ST_IDLE;
         cnt <= '0;
         sync_cnt <= 2'h0;
      end else begin
         case (state)
            XOC_ST_IDLE: begin
               state <= XOC_ST_COUNT;
               cnt <= '0;
            end
            XOC_ST_COUNT: begin
               if (req.ulp_tick) begin
                  if (cnt + 18'h00001 == req.length) begin
                     state <= XOC_ST_SYNC;
                     sync_cnt <= 2'h0;
                  end else begin
                     cnt <= cnt + 18'h00001;
                  end
               end
            end
            XOC_ST_SYNC: begin
               if (req.osc_tick) begin
                  if (sync_cnt == `XOC_SYNC_LAST) begin
                     state <= XOC_ST_READY;
                  end else begin
                     sync_cnt <= sync_cnt + 2'h1;
                  end
               end
            end
            XOC_ST_READY: begin
               state <= XOC_ST_READY;
            end
            default: begin
               state <= XOC_ST_IDLE;
            end
         endcase
      end
   end

   assign ready = (state == XOC_ST_READY);

endmodule

`default_nettype wire

/* File: tb/xoc_ctrl_checker.sv */
// assertion checker for the crystal oscillator control block
`timescale 1ns/1ps
`default_nettype none
`include "xoc_defs.svh"

module xoc_ctrl_checker (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // oscillators
   input wire logic MAIN_OSC_EN,
   input wire logic MAIN_AGC_EN,
   input wire logic [2:0] MAIN_GAIN,
   input wire logic MAIN_READY,
   input wire logic SLOW_OSC_EN,
   input wire logic SLOW_AMP_EN,
   input wire logic SLOW_CLK_OUT_EN,
   input wire logic SLOW_READY
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   logic [3:0] en_run;
   logic wr_main;
   logic wr_slow;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // saturating run length, ready may only rise after several cycles of run
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         en_run <= 4'h0;
      end else if (!SLOW_OSC_EN) begin
         en_run <= 4'h0;
      end else if (en_run != 4'hf) begin
         en_run <= en_run + 4'h1;
      end
   end
   assign wr_main = PSEL && PENABLE && PWRITE && PADDR == `XOC_ADDR_MAIN;
   assign wr_slow = PSEL && PENABLE && PWRITE && PADDR == `XOC_ADDR_SLOW;

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   chk_zero_wait: assert property (PREADY) else $error("pready low");
   chk_err_phase: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
   chk_gain_legal: assert property (MAIN_GAIN <= 3'h4) else $error("reserved gain driven");
   chk_gain_source: assert property ($changed(MAIN_GAIN) |-> $past(wr_main, 2))
      else $error("gain moved without write");
   chk_out_source: assert property ($changed(SLOW_CLK_OUT_EN) |-> $past(wr_slow, 2))
      else $error("clock output moved without write");
   chk_agc_run: assert property (MAIN_AGC_EN |-> MAIN_OSC_EN) else $error("gain control while stopped");
   chk_amp_run: assert property (SLOW_AMP_EN |-> SLOW_OSC_EN) else $error("amplitude ctrl while stopped");
   chk_main_drop: assert property ($fell(MAIN_OSC_EN) |=> !MAIN_READY) else $error("main ready held");
   chk_slow_drop: assert property ($fell(SLOW_OSC_EN) |=> !SLOW_READY) else $error("slow ready held");
   chk_slow_settle: assert property ($rose(SLOW_READY) |-> en_run >= 4'h4)
      else $error("slow ready too early");
endmodule
`default_nettype wire

/* File: tb/xoc_osc_model.sv */
// behavioural oscillators: two gated crystals and the free-running low-power source
`timescale 1ns/1ps
`default_nettype none

module xoc_osc_model #(
   parameter int MAIN_HALF = 150,
   parameter int SLOW_HALF = 350,
   parameter int ULP_HALF = 550
) (
   // run commands
   input wire logic main_en,
   input wire logic slow_en,
   // pin clocks
   output logic main_clk,
   output logic slow_clk,
   output logic ulp_clk
);
   initial begin
      main_clk = 1'b0;
      slow_clk = 1'b0;
      ulp_clk = 1'b0;
   end
   // scaled rates: the real low-power source would make the run far too long
   always #(ULP_HALF) ulp_clk = ~ulp_clk;
   // a crystal stands still low once its run command drops
   always #(MAIN_HALF) main_clk = ~main_clk & main_en;
   always #(SLOW_HALF) slow_clk = ~slow_clk & slow_en;
endmodule
`default_nettype wire

/* File: tb/xoc_ctrl_bench.sv */
// self-checking bench for the crystal oscillator control block
`timescale 1ns/1ps
`default_nettype none
`include "xoc_defs.svh"

module xoc_ctrl_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic standby = 1'b0, req_main = 1'b0, req_slow = 1'b0, main_clk, slow_clk, ulp_clk;
   logic main_osc_en, main_agc_en, main_xtal, main_ready, slow_osc_en, slow_amp_en;
   logic slow_out_en, slow_xtal, slow_ready, irq;
   logic [2:0] main_gain;
   int num_errors = 0, num_checks = 0, cyc;

   always #50 clk = ~clk;

   xoc_ctrl dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .STANDBY(standby), .REQ_MAIN(req_main), .REQ_SLOW(req_slow), .MAIN_OSC_CLK(main_clk),
      .SLOW_OSC_CLK(slow_clk), .ULP_OSC_CLK(ulp_clk), .MAIN_OSC_EN(main_osc_en),
      .MAIN_AGC_EN(main_agc_en), .MAIN_GAIN(main_gain), .MAIN_CRYSTAL_SEL(main_xtal),
      .MAIN_READY(main_ready), .SLOW_OSC_EN(slow_osc_en), .SLOW_AMP_EN(slow_amp_en),
      .SLOW_CLK_OUT_EN(slow_out_en), .SLOW_CRYSTAL_SEL(slow_xtal), .SLOW_READY(slow_ready),
      .IRQ(irq));

   xoc_osc_model osc (.main_en(main_osc_en), .slow_en(slow_osc_en), .main_clk(main_clk),
      .slow_clk(slow_clk), .ulp_clk(ulp_clk));

   // ---------------------------------------------------------------
   // common tasks
   // ---------------------------------------------------------------
   task automatic wrap_up;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; a free edge before setup keeps psel from being assigned twice
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 16, 1'b1);
      // a slave that never answers ends the run here
      if (n >= 16) begin
         wrap_up();
      end
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return main_ready;
         1: return slow_ready;
         2: return main_osc_en;
         3: return slow_osc_en;
         default: return irq;
      endcase
   endfunction

   task automatic wait_on(input int k, input logic v, input int lim);
      cyc = 0;
      while (sig(k) !== v && cyc < lim) begin
         @(posedge clk);
         cyc++;
      end
      chk(sig(k), v);
      if (sig(k) !== v) begin
         wrap_up();
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, `XOC_ADDR_MAIN, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, `XOC_ADDR_SLOW, 32'h0);
      chk(rd, 32'h80);
      apb(1'b1, 12'h020, 32'hffffffff);
      chk(er, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
   endtask

   task automatic t_main;
      apb(1'b1, `XOC_ADDR_MAIN, 32'h0b06);
      wait_on(0, 1'b1, 200);
      chk({main_agc_en, main_gain, main_xtal}, {1'b1, 3'h3, 1'b1});
      // status: main ready and main running, slow still off
      apb(1'b0, `XOC_ADDR_STATUS, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, `XOC_ADDR_MAIN, 32'h0d06);
      apb(1'b0, `XOC_ADDR_MAIN, 32'h0);
      chk(rd, 32'h0b06);
      apb(1'b0, `XOC_ADDR_FLAG, 32'h0);
      chk(rd & 32'h10, 32'h10);
      apb(1'b1, `XOC_ADDR_MAIN, 32'h0b86);
      wait_on(2, 1'b0, 8);
      wait_on(0, 1'b0, 4);
      req_main <= 1'b1;
      wait_on(0, 1'b1, 200);
      req_main <= 1'b0;
      apb(1'b1, `XOC_ADDR_MAIN, 32'h0b06);
      standby <= 1'b1;
      wait_on(2, 1'b0, 8);
      apb(1'b1, `XOC_ADDR_MAIN, 32'h0b46);
      wait_on(2, 1'b1, 8);
      standby <= 1'b0;
   endtask

   task automatic t_slow;
      apb(1'b1, `XOC_ADDR_SLOW, 32'h002e);
      wait_on(1, 1'b1, 60);
      chk({slow_amp_en, slow_out_en, slow_xtal}, 3'h7);
      apb(1'b1, `XOC_ADDR_SLOW, 32'h0);
      wait_on(1, 1'b0, 8);
      chk({slow_amp_en, slow_out_en, slow_xtal}, 3'h0);
      apb(1'b1, `XOC_ADDR_SLOW, 32'h012e);
      wait_on(1, 1'b1, 500);
      chk(cyc > 330, 1'b1);
      apb(1'b1, `XOC_ADDR_SLOW, 32'h00a2);
      wait_on(3, 1'b0, 8);
      req_slow <= 1'b1;
      wait_on(1, 1'b1, 100);
      standby <= 1'b1;
      wait_on(3, 1'b0, 8);
      apb(1'b1, `XOC_ADDR_SLOW, 32'h00e2);
      wait_on(3, 1'b1, 8);
      req_slow <= 1'b0;
      wait_on(3, 1'b0, 8);
      standby <= 1'b0;
   endtask

   // must run last: the freeze bit only clears by reset
   task automatic t_freeze;
      apb(1'b1, `XOC_ADDR_MASK, 32'h20);
      wait_on(4, 1'b0, 4);
      apb(1'b1, `XOC_ADDR_SLOW, 32'h1002);
      apb(1'b1, `XOC_ADDR_SLOW, 32'h0);
      apb(1'b0, `XOC_ADDR_SLOW, 32'h0);
      chk(rd, 32'h1002);
      wait_on(4, 1'b1, 4);
      apb(1'b0, `XOC_ADDR_FLAG, 32'h0);
      chk(rd & 32'h20, 32'h20);
      wait_on(4, 1'b0, 4);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_main();
      t_slow();
      t_freeze();
      wrap_up();
   end
endmodule

bind xoc_ctrl xoc_ctrl_checker chk_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .MAIN_OSC_EN(MAIN_OSC_EN),
   .MAIN_AGC_EN(MAIN_AGC_EN), .MAIN_GAIN(MAIN_GAIN), .MAIN_READY(MAIN_READY),
   .SLOW_OSC_EN(SLOW_OSC_EN), .SLOW_AMP_EN(SLOW_AMP_EN), .SLOW_CLK_OUT_EN(SLOW_CLK_OUT_EN),
   .SLOW_READY(SLOW_READY));
`default_nettype wire
